// *** verilog/word_load_unit_regs.svh ***
// constants for the word load unit: opcodes, fields, exception codes
`ifndef WORD_LOAD_UNIT_REGS_SVH
`define WORD_LOAD_UNIT_REGS_SVH

`define WLU_OP_UPPER_IMM    6'h0f
`define WLU_OP_SIGNED_WORD  6'h23
`define WLU_OP_LEFT_PART    6'h22
`define WLU_OP_COP_PREFIX   4'hc
`define WLU_OPC_MSB         31
`define WLU_OPC_LSB         26
`define WLU_BASE_MSB        25
`define WLU_BASE_LSB        21
`define WLU_TGT_MSB         20
`define WLU_TGT_LSB         16
`define WLU_IMM_MSB         15
`define WLU_EXC_NONE        3'h0
`define WLU_EXC_TLB_REFILL  3'h1
`define WLU_EXC_TLB_INVALID 3'h2
`define WLU_EXC_BUS_ERROR   3'h3
`define WLU_EXC_ADDR_ERROR  3'h4
`define WLU_EXC_COP_UNUSE   3'h5
`define WLU_NUM_COPS        4

`endif

// *** verilog/word_load_pkg.sv ***
// types shared by the word load unit
`default_nettype none
package word_load_pkg;
    typedef enum logic [2:0] {
        op_none                   = 3'h0,
        op_upper_immediate_load   = 3'h1,
        op_signed_word_load       = 3'h2,
        op_coprocessor_word_load  = 3'h3,
        op_left_part_unaligned_load = 3'h4
    } load_op_t;
endpackage
`default_nettype wire

// *** verilog/left_merge.sv ***
// byte merge of the left-part unaligned load
`default_nettype none
module left_merge
(
    input  wire logic [1:0]  i_addr_low,
    input  wire logic        i_cpu_byte_order_mode,
    input  wire logic [31:0] i_mem_word,
    input  wire logic [31:0] i_old_word,
    output logic      [31:0] o_merged
);
    logic [1:0] byte_sel;

    assign byte_sel = i_addr_low ^ {2{i_cpu_byte_order_mode}};

    always_comb
    begin
        case (byte_sel)
            2'h0: o_merged = {i_mem_word[7:0], i_old_word[23:0]};
            2'h1: o_merged = {i_mem_word[15:0], i_old_word[15:0]};
            2'h2: o_merged = {i_mem_word[23:0], i_old_word[7:0]};
            default: o_merged = i_mem_word;
        endcase
    end
endmodule
`default_nettype wire

// *** verilog/word_load_unit.sv ***
// word load execution unit: decode, address, checks, merge and writeback
// ----------------------------------------------------------------
// Functional notes
// - upper immediate, low zeros, sign extended
// - signed word load opcode and fields
// - address is base plus signed offset
// - aligned word fetched and sign extended
// - low address bits nonzero raise error
// - word load reports only four exceptions
// - coprocessor load delivers to unit zz
// - four coprocessor units, zero to three
// - unusable coprocessor in user mode traps
// - no coprocessor load for unit zero
// - fetch now, hand word next cycle
// - left load merges upper bytes
// - sixty four bit copies bit 31 up
// - lanes from address bits and order
// - back to back load merges forwarded
// - left plus right gives signed word
// ----------------------------------------------------------------
`default_nettype none
`include "word_load_unit_regs.svh"
module word_load_unit
#(
    parameter int REG_WIDTH = 64
)
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_clk_en,
    input  wire logic                 i_valid,
    input  wire logic [31:0]          i_instr,
    input  wire logic [REG_WIDTH-1:0] i_base_value,
    input  wire logic [REG_WIDTH-1:0] i_target_value,
    input  wire logic                 i_cpu_byte_order_mode,
    input  wire logic                 i_user_mode,
    input  wire logic [3:0]           i_cop_usable,
    input  wire logic [3:0]           i_cop_present,
    input  wire logic [63:0]          i_mem_data,
    input  wire logic                 i_tlb_refill,
    input  wire logic                 i_tlb_invalid,
    input  wire logic                 i_bus_error,
    output logic [REG_WIDTH-1:0]      o_effective_address,
    output logic                      o_mem_read,
    output logic                      o_wb_en,
    output logic [4:0]                o_wb_reg,
    output logic [REG_WIDTH-1:0]      o_wb_data,
    output logic                      o_exc_valid,
    output logic [2:0]                o_exc_code,
    output logic                      o_reserved_instr,
    output logic [3:0]                o_coprocessor_word_handoff,
    output logic [4:0]                o_cop_reg,
    output logic [31:0]               o_cop_data
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;

    // the release is synchronised so every flop leaves reset on the
    // same edge, whatever the phase of the external release
    // two stage reset release
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [5:0]                 opcode;
    logic [4:0]                 base_field;
    logic [4:0]                 target_register_field;
    logic [15:0]                offset;
    logic [1:0]                 cop_num;
    word_load_pkg::load_op_t    op;
    logic                       is_cop_pattern;

    assign opcode                = i_instr[`WLU_OPC_MSB:`WLU_OPC_LSB];
    assign base_field            = i_instr[`WLU_BASE_MSB:`WLU_BASE_LSB];
    assign target_register_field = i_instr[`WLU_TGT_MSB:`WLU_TGT_LSB];
    assign offset                = i_instr[`WLU_IMM_MSB:0];
    assign cop_num               = opcode[1:0];
    assign is_cop_pattern        = (opcode[5:2] == `WLU_OP_COP_PREFIX);

    // opcode classification
    always_comb
    begin
        op = word_load_pkg::op_none;
        if (opcode == `WLU_OP_UPPER_IMM)
            op = word_load_pkg::op_upper_immediate_load;
        else if (opcode == `WLU_OP_SIGNED_WORD)
            op = word_load_pkg::op_signed_word_load;
        else if (opcode == `WLU_OP_LEFT_PART)
            op = word_load_pkg::op_left_part_unaligned_load;
        else if (is_cop_pattern && (cop_num != 2'h0))
            op = word_load_pkg::op_coprocessor_word_load;
    end

    // ----------------------------------------------------------------
    // address and checks
    // ----------------------------------------------------------------
    logic [REG_WIDTH-1:0] ea;
    logic                 misaligned;
    logic                 aligned_kind;
    logic                 cop_unusable;
    logic                 is_mem;
    logic [2:0]           exc;

    assign ea = i_base_value + {{(REG_WIDTH-16){offset[15]}}, offset};
    assign aligned_kind = (op == word_load_pkg::op_signed_word_load) ||
                          (op == word_load_pkg::op_coprocessor_word_load);
    assign misaligned = aligned_kind && (ea[1:0] != 2'h0);
    assign cop_unusable = (op == word_load_pkg::op_coprocessor_word_load) &&
                          i_user_mode && !i_cop_usable[cop_num];
    assign is_mem = aligned_kind || (op == word_load_pkg::op_left_part_unaligned_load);

    // priority: unusable unit first, then alignment, then translation,
    // then bus faults; only one code is reported per instruction
    // exception priority, limited set
    always_comb
    begin
        exc = `WLU_EXC_NONE;
        if (i_valid && i_clk_en)
        begin
            if (cop_unusable)
                exc = `WLU_EXC_COP_UNUSE;
            else if (misaligned)
                exc = `WLU_EXC_ADDR_ERROR;
            else if (is_mem && i_tlb_refill)
                exc = `WLU_EXC_TLB_REFILL;
            else if (is_mem && i_tlb_invalid)
                exc = `WLU_EXC_TLB_INVALID;
            else if (is_mem && i_bus_error)
                exc = `WLU_EXC_BUS_ERROR;
        end
    end

    // address out and fetch request
    assign o_effective_address = ea;
    assign o_mem_read = i_valid && is_mem && !misaligned && !cop_unusable;

    // ----------------------------------------------------------------
    // data shaping
    // ----------------------------------------------------------------
    logic [31:0]          mem_word;
    logic                 lane_hi;
    logic [31:0]          merged;
    logic [31:0]          old_word;
    logic [31:0]          result_word;
    logic                 fwd_hit;
    logic [31:0]          last_word;
    logic [4:0]           last_reg;
    logic                 last_valid;

    // lane by bit two and order
    assign lane_hi = (REG_WIDTH > 32) ? (ea[2] ^ i_cpu_byte_order_mode) : 1'b0;
    assign mem_word = lane_hi ? i_mem_data[63:32] : i_mem_data[31:0];

    // forwarding covers only this unit's own last write, so a stale
    // register file value is never merged after a back to back load
    // forward previous load result
    assign fwd_hit  = last_valid && (last_reg == target_register_field);
    assign old_word = fwd_hit ? last_word : i_target_value[31:0];

    // byte merge for the left part load
    left_merge u_merge
    (
        .i_addr_low            (ea[1:0]),
        .i_cpu_byte_order_mode (i_cpu_byte_order_mode),
        .i_mem_word            (mem_word),
        .i_old_word            (old_word),
        .o_merged              (merged)
    );

    // result word per operation
    always_comb
    begin
        case (op)
            word_load_pkg::op_upper_immediate_load: result_word = {offset, 16'h0000};
            word_load_pkg::op_signed_word_load:     result_word = mem_word;
            word_load_pkg::op_left_part_unaligned_load: result_word = merged;
            default:                                result_word = mem_word;
        endcase
    end

    // ----------------------------------------------------------------
    // writeback and exception report
    // ----------------------------------------------------------------
    // write only for clean register loads
    logic wb_now;
    assign wb_now = i_valid && (exc == `WLU_EXC_NONE) &&
                    (op != word_load_pkg::op_none) &&
                    (op != word_load_pkg::op_coprocessor_word_load);

    always_ff @(posedge i_mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            o_wb_en    <= 1'b0;
            o_wb_reg   <= 5'h00;
            o_wb_data  <= '0;
            last_valid <= 1'b0;
            last_reg   <= 5'h00;
            last_word  <= 32'h0000_0000;
        end
        else if (i_clk_en)
        begin
            o_wb_en    <= wb_now;
            last_valid <= wb_now;
            if (wb_now)
            begin
                o_wb_reg  <= target_register_field;
                last_reg  <= target_register_field;
                last_word <= result_word;
                o_wb_data <= {{(REG_WIDTH-32){result_word[31]}}, result_word};
            end
        end
    end

    // exception report, one cycle pulse
    always_ff @(posedge i_mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            o_exc_valid      <= 1'b0;
            o_exc_code       <= `WLU_EXC_NONE;
            o_reserved_instr <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_exc_valid      <= (exc != `WLU_EXC_NONE);
            o_exc_code       <= exc;
            o_reserved_instr <= i_valid && (op == word_load_pkg::op_coprocessor_word_load) &&
                                (exc == `WLU_EXC_NONE) && !i_cop_present[cop_num];
        end
    end

    // ----------------------------------------------------------------
    // coprocessor handoff
    // ----------------------------------------------------------------
    // clean transfer to a present unit
    logic cop_go;
    assign cop_go = i_valid && (op == word_load_pkg::op_coprocessor_word_load) &&
                    (exc == `WLU_EXC_NONE) && i_cop_present[cop_num];

    always_ff @(posedge i_mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            o_cop_reg  <= 5'h00;
            o_cop_data <= 32'h0000_0000;
        end
        else if (i_clk_en && cop_go)
        begin
            o_cop_reg  <= target_register_field;
            o_cop_data <= mem_word;
        end
    end

    for (genvar u = 0; u < `WLU_NUM_COPS; u++)
    begin : g_unit
        always_ff @(posedge i_mclk or negedge rst_sync_n)
        begin
            if (!rst_sync_n)
                o_coprocessor_word_handoff[u] <= 1'b0;
            else if (i_clk_en)
                o_coprocessor_word_handoff[u] <= cop_go && (cop_num == 2'(u));
        end
    end
endmodule
`default_nettype wire

// *** verif/word_load_mem_model.sv ***
// memory system model: answers a fetched doubleword in the request cycle
`default_nettype none
module word_load_mem_model
(
    input  wire logic [63:0] i_addr,
    input  wire logic        i_read,
    output logic      [63:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] word;
    always_comb
    begin
        word = {32'hf1e2_d3c4 ^ i_addr[31:0], 32'h8a7b_6c5d ^ i_addr[31:0]};
        o_data = i_read ? word : ~word; // idle bus shows the inverse
    end
endmodule
`default_nettype wire

// *** verif/word_load_unit_chk.sv ***
// port assertions for the word load unit
`default_nettype none
`include "word_load_unit_regs.svh"
module word_load_unit_chk
#(
    parameter int REG_WIDTH = 64
)
(
    input wire logic                 i_mclk,
    input wire logic                 i_reset_n,
    input wire logic                 i_clk_en,
    input wire logic                 i_valid,
    input wire logic [31:0]          i_instr,
    input wire logic [REG_WIDTH-1:0] i_base_value,
    input wire logic                 i_user_mode,
    input wire logic [3:0]           i_cop_usable,
    input wire logic [3:0]           i_cop_present,
    input wire logic                 i_tlb_refill,
    input wire logic                 i_tlb_invalid,
    input wire logic                 i_bus_error,
    input wire logic [REG_WIDTH-1:0] o_effective_address,
    input wire logic                 o_wb_en,
    input wire logic [4:0]           o_wb_reg,
    input wire logic [REG_WIDTH-1:0] o_wb_data,
    input wire logic                 o_exc_valid,
    input wire logic [2:0]           o_exc_code,
    input wire logic [3:0]           o_coprocessor_word_handoff,
    input wire logic [4:0]           o_cop_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    // request decode helpers
    wire logic [5:0] opc = i_instr[31:26];
    wire logic [1:0] z = opc[1:0];
    wire logic req = i_valid && i_clk_en;
    wire logic flt = i_tlb_refill || i_tlb_invalid || i_bus_error;
    wire logic mis = o_effective_address[1:0] != 2'h0;
    wire logic cop = opc[5:2] == `WLU_OP_COP_PREFIX && z != 2'h0;
    wire logic sgn = o_wb_data[REG_WIDTH-1:31] == {(REG_WIDTH-31){o_wb_data[31]}};
    // clean word and coprocessor requests
    sequence s_word_ok;
        req && opc == `WLU_OP_SIGNED_WORD && !mis && !flt;
    endsequence
    sequence s_cop_go;
        req && cop && i_cop_present[z] && i_cop_usable[z] && !mis && !flt;
    endsequence
    a_upper_imm_value: assert property (req && opc == `WLU_OP_UPPER_IMM |=> o_wb_en &&
        o_wb_data == {{(REG_WIDTH-32){$past(i_instr[15])}}, $past(i_instr[15:0]), 16'h0000})
        else $error("upper immediate result wrong");
    a_addr_sum: assert property (req && (opc == `WLU_OP_SIGNED_WORD || cop) |->
        o_effective_address == i_base_value + {{(REG_WIDTH-16){i_instr[15]}}, i_instr[15:0]})
        else $error("effective address wrong");
    a_word_sign_ext: assert property (s_word_ok |=> o_wb_en && sgn &&
        o_wb_reg == $past(i_instr[20:16])) else $error("word load writeback wrong");
    a_addr_error_raise: assert property (req && opc == `WLU_OP_SIGNED_WORD && mis |=>
        o_exc_valid && o_exc_code == `WLU_EXC_ADDR_ERROR && !o_wb_en)
        else $error("misaligned word load not trapped");
    a_word_fault_code: assert property (req && opc == `WLU_OP_SIGNED_WORD && !mis && flt
        |=> o_exc_valid && !o_wb_en && o_exc_code == ($past(i_tlb_refill) ?
        `WLU_EXC_TLB_REFILL : $past(i_tlb_invalid) ? `WLU_EXC_TLB_INVALID : `WLU_EXC_BUS_ERROR))
        else $error("word load fault code wrong");
    a_cop_handoff_unit: assert property (s_cop_go |=>
        o_coprocessor_word_handoff == 4'h1 << $past(z) && o_cop_reg == $past(i_instr[20:16]))
        else $error("coprocessor handoff wrong");
    a_cop_unusable_trap: assert property (req && cop && i_cop_present[z] && i_user_mode &&
        !i_cop_usable[z] |=> o_exc_valid && o_exc_code == `WLU_EXC_COP_UNUSE &&
        o_coprocessor_word_handoff == 4'h0) else $error("unusable unit not trapped");
    a_cop_zero_quiet: assert property (req && opc == {`WLU_OP_COP_PREFIX, 2'h0} |=>
        !o_wb_en && !o_exc_valid && o_coprocessor_word_handoff == 4'h0)
        else $error("unit zero load produced output");
    a_handoff_one_hot: assert property ($onehot0(o_coprocessor_word_handoff))
        else $error("handoff to several units");
    a_left_sign_copy: assert property (req && opc == `WLU_OP_LEFT_PART && !flt |=>
        o_wb_en && sgn) else $error("left load upper word not sign copy");
endmodule
bind word_load_unit word_load_unit_chk #(.REG_WIDTH(REG_WIDTH)) chk (.i_mclk, .i_reset_n,
    .i_clk_en, .i_valid, .i_instr, .i_base_value, .i_user_mode, .i_cop_usable, .i_cop_present,
    .i_tlb_refill, .i_tlb_invalid, .i_bus_error, .o_effective_address, .o_wb_en, .o_wb_reg,
    .o_wb_data, .o_exc_valid, .o_exc_code, .o_coprocessor_word_handoff, .o_cop_reg);
`default_nettype wire

// *** verif/word_load_unit_tb_top.sv ***
// bench for the word load unit: scenarios, compares and verdict
`default_nettype none
`include "word_load_unit_regs.svh"
module word_load_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_n, vld, ord, rf, ti, be, rd, wbe, exv, mode, usr, cen, rsv, rdc;
    logic        umode, ecfg;
    logic [31:0] ins_q, cpd;
    logic [63:0] bas, tgt, mem, ea, wbd, eac, tv;
    logic [3:0]  use_q, hnd, ucfg, prs, pcfg;
    logic [4:0]  wbr, cpr;
    logic [2:0]  exc;
    int          miscompares, samples_checked;
    word_load_unit #(.REG_WIDTH(64)) dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_clk_en(cen),
        .i_valid(vld), .i_instr(ins_q), .i_base_value(bas), .i_target_value(tgt),
        .i_cpu_byte_order_mode(ord), .i_user_mode(usr), .i_cop_usable(use_q),
        .i_cop_present(prs), .i_mem_data(mem), .i_tlb_refill(rf), .i_tlb_invalid(ti),
        .i_bus_error(be), .o_effective_address(ea), .o_mem_read(rd), .o_wb_en(wbe),
        .o_wb_reg(wbr), .o_wb_data(wbd), .o_exc_valid(exv), .o_exc_code(exc),
        .o_reserved_instr(rsv), .o_coprocessor_word_handoff(hnd), .o_cop_reg(cpr),
        .o_cop_data(cpd));
    word_load_mem_model mm (.i_addr(ea), .i_read(rd), .o_data(mem));
    // expected word lane and left merge
    function automatic logic [31:0] mw(input logic [63:0] a, input logic o);
        mw = (a[2] ^ o) ? 32'hf1e2_d3c4 ^ a[31:0] : 32'h8a7b_6c5d ^ a[31:0];
    endfunction
    function automatic logic [31:0] lm(input logic [31:0] m, p, input logic [1:0] b);
        lm = (m << (24 - 8 * b)) | (p & ((32'h1 << (24 - 8 * b)) - 32'h1));
    endfunction
    function automatic logic [63:0] sx(input logic [31:0] w);
        sx = {{32{w[31]}}, w};
    endfunction
    task automatic chk(input logic [63:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one instruction, result sampled one edge later
    task automatic run(input logic [5:0] op, input logic [4:0] rt, input logic [15:0] off,
                       input logic [63:0] b, input logic [2:0] f);
        @(posedge mclk);
        ins_q <= {op, 5'h00, rt, off};
        bas <= b;
        tgt <= tv;
        {rf, ti, be} <= f;
        ord <= mode;
        use_q <= ucfg;
        usr <= umode;
        prs <= pcfg;
        cen <= ecfg;
        vld <= 1'b1;
        #1;
        eac = ea;
        rdc = rd;
        @(posedge mclk);
        vld <= 1'b0;
        {rf, ti, be} <= 3'h0;
        #1;
    endtask
    task automatic t_upper();
        run(`WLU_OP_UPPER_IMM, 5'h05, 16'h8001, 64'h0, 3'h0);
        chk(wbd, 64'hffff_ffff_8001_0000);
        chk(rdc, 1'b0);
        run(`WLU_OP_UPPER_IMM, 5'h06, 16'h7ffe, 64'h0, 3'h0);
        chk(wbd, 64'h0000_0000_7ffe_0000);
    endtask
    task automatic t_word();
        for (int o = 0; o < 2; o++)
        begin
            mode = o[0];
            run(`WLU_OP_SIGNED_WORD, 5'h07, 16'hfffc, 64'h100, 3'h0);
            chk(eac, 64'hfc);
            chk(wbr, 5'h07);
            chk(rdc, 1'b1);
            chk(wbd, sx(mw(64'hfc, mode)));
        end
    endtask
    task automatic t_fault();
        for (int k = 1; k < 4; k++)
        begin
            run(`WLU_OP_SIGNED_WORD, 5'h08, 16'h0000, 64'h200 + k, 3'h0);
            chk(exc, `WLU_EXC_ADDR_ERROR);
            chk(exv, 1'b1);
            chk(rdc, 1'b0);
            run(`WLU_OP_SIGNED_WORD, 5'h08, 16'h0000, 64'h200, 3'h4 >> (k - 1));
            chk(exc, k);
            chk(wbe, 1'b0);
        end
    endtask
    task automatic t_cop();
        ucfg = 4'he;
        for (int z = 0; z < 4; z++)
        begin
            run({`WLU_OP_COP_PREFIX, z[1:0]}, 5'h09, 16'h0008, 64'h40, 3'h0);
            chk(hnd, z ? 4'h1 << z : 4'h0);
            if (z != 0)
            begin
                chk(cpd, mw(64'h48, mode));
                chk(cpr, 5'h09);
            end
        end
        ucfg = 4'h0;
        run({`WLU_OP_COP_PREFIX, 2'h2}, 5'h09, 16'h0008, 64'h40, 3'h0);
        chk(exc, `WLU_EXC_COP_UNUSE);
    endtask
    task automatic t_left();
        tv = 64'h5555_5555_1122_3344;
        for (int k = 0; k < 8; k++)
        begin
            mode = k[2];
            run(`WLU_OP_LEFT_PART, 5'h0a, 16'h0000, 64'h80 + k[1:0], 3'h0);
            chk(wbd, sx(lm(mw(64'h80 + k[1:0], mode), tv[31:0], k[1:0] ^ {2{mode}})));
        end
    endtask
    task automatic t_fwd();
        @(posedge mclk);
        ins_q <= {`WLU_OP_SIGNED_WORD, 5'h00, 5'h0b, 16'h0000};
        bas <= 64'h100;
        ord <= 1'b0;
        tgt <= 64'h0;
        vld <= 1'b1;
        @(posedge mclk);
        ins_q <= {`WLU_OP_LEFT_PART, 5'h00, 5'h0b, 16'h0001};
        @(posedge mclk);
        vld <= 1'b0;
        #1;
        chk(wbd, sx(lm(mw(64'h101, 1'b0), mw(64'h100, 1'b0), 2'h1)));
    endtask
    // kernel mode, missing unit, frozen clock
    task automatic t_gate();
        umode = 1'b0;
        ucfg = 4'h0;
        run({`WLU_OP_COP_PREFIX, 2'h1}, 5'h0c, 16'h0004, 64'h40, 3'h0);
        chk(hnd, 4'h2);
        chk(exv, 1'b0);
        pcfg = 4'h7;
        run({`WLU_OP_COP_PREFIX, 2'h3}, 5'h0c, 16'h0004, 64'h40, 3'h0);
        chk(rsv, 1'b1);
        chk(hnd, 4'h0);
        {umode, pcfg} = 5'h1f;
        run(`WLU_OP_UPPER_IMM, 5'h0d, 16'h1234, 64'h0, 3'h0);
        ecfg = 1'b0;
        run(`WLU_OP_UPPER_IMM, 5'h0d, 16'h8765, 64'h0, 3'h0);
        chk(wbe, 1'b0);
        chk(wbd, 64'h0000_0000_1234_0000);
        ecfg = 1'b1;
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // 40 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // watchdog: the run needs under 100 cycles after reset
    initial
    begin
        #20000;
        miscompares++;
        summarize();
    end
    // reset, then the scenarios
    initial
    begin
        {rst_n, vld, ord, rf, ti, be, mode} = 7'h00;
        ins_q = 32'h0;
        {bas, tgt, tv} = 192'h0;
        {use_q, ucfg} = 8'hee;
        {usr, cen, umode, ecfg} = 4'hf;
        {prs, pcfg} = 8'hff;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_upper();
        t_word();
        t_fault();
        t_cop();
        t_fwd();
        t_left();
        t_gate();
        summarize();
    end
endmodule
`default_nettype wire
